// ===== design/register_file_paging_decoder.sv
/*
 * Register file address decoder: page select, set 1 / set 2 overlay,
 * set 1 banks, working pointers and the start-option cells.
 * Assumes the cpu core holds each request for one cycle and that the
 * storage behind the decoded outputs is a separate memory.
 */
`timescale 1ns/100ps
`include "regfile_defines.svh"

module register_file_paging_decoder (
	input wire logic i_clk, // system clock, 125 MHz
	input wire logic i_arst_n, // async reset, active low
	input wire logic i_req, // register access request
	input wire logic i_we, // access is a write
	input wire logic i_pair, // access is a 16-bit pair
	input wire regfile_pkg::access_mode_e i_mode, // addressing mode
	input wire logic [7:0] i_addr, // logical register address
	input wire logic [7:0] i_wdata, // write data
	input wire regfile_pkg::ptr_cmd_e i_cmd, // pointer or bank instruction
	input wire logic [7:0] i_cmd_operand, // instruction operand
	input wire logic i_pm_we, // run-time program-memory write
	input wire logic i_prog_we, // external programmer write
	input wire logic [15:0] i_pm_addr, // program-memory address
	input wire logic [7:0] i_pm_wdata, // program-memory write data
	output logic o_valid, // decoded access ready
	output regfile_pkg::area_e o_area, // resolved region
	output logic [3:0] o_page, // resolved page
	output logic [7:0] o_offset, // resolved address, pair high byte
	output logic [7:0] o_pair_low, // pair low byte address
	output logic o_int_hit, // access hit a decoder register
	output logic o_page_err, // set 2 access on a page without it
	output logic [7:0] o_rdata, // decoder register read data
	output logic o_bank, // current set 1 bank
	output logic [7:0] o_page_sel, // page select register
	output logic [7:0] o_wsp0, // first working pointer
	output logic [7:0] o_wsp1, // second working pointer
	output logic [7:0] o_opt_rdata, // stored option byte
	output logic [15:0] o_start_option // active start option
);

	typedef struct packed {
		logic valid;
		regfile_pkg::area_e area;
		logic [3:0] page;
		logic [7:0] offset;
		logic [7:0] pair_low;
		logic int_hit;
		logic page_err;
		logic [7:0] rdata;
		logic bank;
		logic [7:0] page_sel;
		logic [7:0] wsp0;
		logic [7:0] wsp1;
	} dec_state_s;

	dec_state_s st_q;
	dec_state_s st_d;
	regfile_if rif();

	logic [7:0] eff_addr;
	logic [3:0] req_page;
	logic set1_hit;
	logic set2_hit;

	// resolver sees the live pointers so a working access uses current values
	assign rif.addr = i_addr;
	assign rif.mode = i_mode;
	assign rif.wsp0 = st_q.wsp0;
	assign rif.wsp1 = st_q.wsp1;

	working_addr_resolver u_resolver (
		.rif(rif)
	);

	option_store u_option (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_pm_we(i_pm_we),
		.i_prog_we(i_prog_we),
		.i_pm_addr(i_pm_addr),
		.i_pm_wdata(i_pm_wdata),
		.o_opt_rdata(o_opt_rdata),
		.o_start_option(o_start_option)
	);

	// pick the page nibble by direction
	assign req_page = i_we ? st_q.page_sel[`RF_PAGE_DST_LSB +: 4] :
		st_q.page_sel[`RF_PAGE_SRC_LSB +: 4];
	assign eff_addr = rif.res_addr;
	// working accesses into the top range always land in set 1
	assign set1_hit = (eff_addr >= `RF_SET_BASE) &&
		(rif.working || i_mode == regfile_pkg::MODE_DIRECT);
	assign set2_hit = (eff_addr >= `RF_SET_BASE) && !set1_hit;

	// set 1 region from the resolved address and current bank
	function automatic regfile_pkg::area_e set1_area(input logic [7:0] a, input logic bank);
		if (a >= `RF_BANK_BASE) begin
			return bank ? regfile_pkg::AREA_BANK1 : regfile_pkg::AREA_BANK0;
		end else if (a >= `RF_SYS_BASE) begin
			return regfile_pkg::AREA_SYSTEM;
		end
		return regfile_pkg::AREA_COMMON;
	endfunction

	// decoder registers live in the system part of set 1
	function automatic logic is_own_reg(input logic [7:0] a);
		return a == `RF_OFS_WSP0 || a == `RF_OFS_WSP1 || a == `RF_OFS_PAGE;
	endfunction

	// next state: decode the request, then register and instruction updates
	always_comb begin
		st_d = st_q;
		st_d.valid = i_req;
		st_d.int_hit = 1'b0;
		st_d.page_err = 1'b0;
		st_d.rdata = 8'h00;
		if (i_req) begin
			if (set1_hit) begin
				st_d.area = set1_area(eff_addr, st_q.bank);
				st_d.page = 4'h0;
				st_d.int_hit = is_own_reg(eff_addr);
			end else if (set2_hit) begin
				st_d.area = regfile_pkg::AREA_SET2;
				st_d.page = req_page;
				st_d.page_err = req_page > `RF_SET2_MAX_PAGE;
			end else begin
				st_d.area = regfile_pkg::AREA_PRIME;
				st_d.page = req_page;
			end
			// a pair starts at the even byte, low byte follows at odd
			st_d.offset = i_pair ? {eff_addr[7:1], 1'b0} : eff_addr;
			st_d.pair_low = {eff_addr[7:1], 1'b1};
			if (set1_hit && !i_we) begin
				case (eff_addr)
					`RF_OFS_WSP0: st_d.rdata = st_q.wsp0;
					`RF_OFS_WSP1: st_d.rdata = st_q.wsp1;
					`RF_OFS_PAGE: st_d.rdata = st_q.page_sel;
					default: st_d.rdata = 8'h00;
				endcase
			end
			if (set1_hit && i_we) begin
				case (eff_addr)
					`RF_OFS_WSP0: st_d.wsp0 = i_wdata;
					`RF_OFS_WSP1: st_d.wsp1 = i_wdata;
					`RF_OFS_PAGE: st_d.page_sel = i_wdata;
					default: st_d.rdata = 8'h00;
				endcase
			end
		end
		// an instruction in the same cycle as a load wins, it is the newer intent
		case (i_cmd)
			regfile_pkg::CMD_SET_BOTH: begin
				st_d.wsp0 = i_cmd_operand;
				st_d.wsp1 = 8'(i_cmd_operand + `RF_SLICE_STEP);
			end
			regfile_pkg::CMD_SET_FIRST: begin
				st_d.wsp0 = i_cmd_operand;
			end
			regfile_pkg::CMD_SET_SECOND: begin
				st_d.wsp1 = i_cmd_operand;
			end
			regfile_pkg::CMD_BANK_ZERO: begin
				st_d.bank = 1'b0;
			end
			regfile_pkg::CMD_BANK_ONE: begin
				st_d.bank = 1'b1;
			end
			default: begin
				st_d.bank = st_d.bank;
			end
		endcase
	end

	// reset puts both pointers on the common area and page 0 everywhere
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_q <= '0;
			st_q.area <= regfile_pkg::AREA_NONE;
			st_q.wsp0 <= `RF_RST_WSP0;
			st_q.wsp1 <= `RF_RST_WSP1;
			st_q.page_sel <= `RF_RST_PAGE;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_valid = st_q.valid;
	assign o_area = st_q.area;
	assign o_page = st_q.page;
	assign o_offset = st_q.offset;
	assign o_pair_low = st_q.pair_low;
	assign o_int_hit = st_q.int_hit;
	assign o_page_err = st_q.page_err;
	assign o_rdata = st_q.rdata;
	assign o_bank = st_q.bank;
	assign o_page_sel = st_q.page_sel;
	assign o_wsp0 = st_q.wsp0;
	assign o_wsp1 = st_q.wsp1;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_direct_top;
		i_req && i_mode == regfile_pkg::MODE_DIRECT && i_addr >= 8'hD0;
	endsequence

	sequence s_indirect_top;
		i_req && (i_mode == regfile_pkg::MODE_INDIRECT || i_mode == regfile_pkg::MODE_INDEXED)
			&& i_addr >= 8'hC0;
	endsequence

	// bank one, then a cycle with no instruction, so the bank is settled
	sequence s_bank_one_idle;
		i_cmd == regfile_pkg::CMD_BANK_ONE ##1 i_cmd == regfile_pkg::CMD_NONE;
	endsequence

	chk_direct_set_one: assert property (s_direct_top |=>
		o_area != regfile_pkg::AREA_SET2 && o_area != regfile_pkg::AREA_PRIME && o_page == 4'h0)
		else $error("direct top access left set 1");
	chk_indirect_set_two: assert property (s_indirect_top |=>
		o_area == regfile_pkg::AREA_SET2 && o_offset[7:6] == 2'h3)
		else $error("indirect top access missed set 2");
	chk_bank_select: assert property (
		(s_bank_one_idle ##1 (s_direct_top and i_addr >= 8'hE0))
		|=> o_area == regfile_pkg::AREA_BANK1)
		else $error("bank one not applied");
	chk_set_both_step: assert property (
		i_cmd == regfile_pkg::CMD_SET_BOTH |=> o_wsp0 == $past(i_cmd_operand)
		&& o_wsp1 == 8'($past(i_cmd_operand) + 8'h08))
		else $error("set both pointers gave wrong pair");
	chk_single_pointer: assert property (
		(i_cmd == regfile_pkg::CMD_SET_SECOND && !(i_req && i_we)) |=> $stable(o_wsp0))
		else $error("second pointer instruction touched the first");
	chk_working_join: assert property (
		(i_req && i_mode == regfile_pkg::MODE_WORK4 && !i_pair && i_addr[3])
		|=> o_offset == {$past(o_wsp1[7:3]), $past(i_addr[2:0])})
		else $error("working address not joined to second pointer");
	chk_work_no_set2: assert property (
		(i_req && i_mode == regfile_pkg::MODE_WORK4) |=> o_area != regfile_pkg::AREA_SET2)
		else $error("working access reached set 2");
	chk_write_dest_page: assert property (
		(i_req && i_we && i_mode == regfile_pkg::MODE_INDIRECT && i_addr < 8'hC0)
		|=> o_page == $past(o_page_sel[7:4]) && o_area == regfile_pkg::AREA_PRIME)
		else $error("write did not use destination page");
	chk_pair_order: assert property (
		(i_req && i_pair) |=> !o_offset[0] && o_pair_low == (o_offset | 8'h01))
		else $error("register pair byte order wrong");

	// both pointers come out of reset on the common area
	chk_reset_pointers: assert property (
		$rose(i_arst_n) |-> o_wsp0 == `RF_RST_WSP0 && o_wsp1 == `RF_RST_WSP1)
		else $error("pointers not on the common area after reset");

	// page 0 for both directions and bank zero after reset
	chk_reset_page: assert property (
		$rose(i_arst_n) |-> o_page_sel == `RF_RST_PAGE && !o_bank)
		else $error("page select or bank not cleared by reset");

	// a plain load of the page select lands the next cycle
	chk_page_load: assert property (
		(i_req && i_we && i_mode == regfile_pkg::MODE_DIRECT && i_addr == `RF_OFS_PAGE)
		|=> o_page_sel == $past(i_wdata))
		else $error("page select load lost");

	// a plain load of the second pointer with no instruction in the way
	chk_pointer_load: assert property (
		(i_req && i_we && i_mode == regfile_pkg::MODE_DIRECT && i_addr == `RF_OFS_WSP1
			&& i_cmd == regfile_pkg::CMD_NONE) |=> o_wsp1 == $past(i_wdata))
		else $error("second pointer load lost");

	// reading the second pointer flags the hit and returns its old value
	chk_pointer_read: assert property (
		(i_req && !i_we && i_mode == regfile_pkg::MODE_DIRECT && i_addr == `RF_OFS_WSP1)
		|=> o_int_hit && o_rdata == $past(o_wsp1))
		else $error("second pointer read back wrong");

	// the single-pointer form for the first pointer leaves the second alone
	chk_set_first_only: assert property (
		(i_cmd == regfile_pkg::CMD_SET_FIRST && !(i_req && i_we))
		|=> o_wsp0 == $past(i_cmd_operand) && $stable(o_wsp1))
		else $error("first pointer instruction misapplied");

	// bank instructions take effect on the next cycle
	chk_bank_follows: assert property (
		(i_cmd == regfile_pkg::CMD_BANK_ZERO || i_cmd == regfile_pkg::CMD_BANK_ONE)
		|=> o_bank == ($past(i_cmd) == regfile_pkg::CMD_BANK_ONE))
		else $error("bank instruction not applied");

	// below the set boundary every non-working form lands in the prime area
	chk_prime_any_mode: assert property (
		(i_req && i_mode != regfile_pkg::MODE_WORK4 && i_addr < `RF_SET_BASE)
		|=> o_area == regfile_pkg::AREA_PRIME)
		else $error("low address missed the prime area");

	// reads take the source nibble of the page select
	chk_read_src_page: assert property (
		(i_req && !i_we && i_mode == regfile_pkg::MODE_INDEXED && i_addr < `RF_SET_BASE)
		|=> o_page == $past(o_page_sel[3:0]))
		else $error("read did not use source page");

	// set 2 only exists on the lower pages, higher ones are flagged
	chk_set2_page_flag: assert property (
		s_indirect_top |=> o_page_err == (o_page > `RF_SET2_MAX_PAGE))
		else $error("set 2 page flag wrong");

	// the page select never moves set 1, which always reports page 0
	chk_set1_no_page: assert property (
		i_req |=> o_area == regfile_pkg::AREA_PRIME || o_area == regfile_pkg::AREA_SET2
			|| o_page == 4'h0)
		else $error("set 1 access carried a page");

	// direct system addresses sit in the unbanked half
	chk_system_area: assert property (
		(s_direct_top and i_addr < `RF_BANK_BASE) |=> o_area == regfile_pkg::AREA_SYSTEM)
		else $error("direct system address misplaced");

	// a working access is common exactly when it resolves into C0 to CF
	chk_common_area: assert property (
		(i_req && i_mode == regfile_pkg::MODE_WORK4)
		|=> (o_offset[7:4] == `RF_WORK_NIB) == (o_area == regfile_pkg::AREA_COMMON))
		else $error("common area decode wrong");

	// the long working form joins the chosen pointer to the low address bits
	chk_long_working: assert property (
		(i_req && i_mode == regfile_pkg::MODE_DIRECT && i_addr[7:4] == `RF_WORK_NIB
			&& !i_pair)
		|=> o_offset == {$past(i_addr[3]) ? $past(o_wsp1[7:3]) : $past(o_wsp0[7:3]),
			$past(i_addr[2:0])})
		else $error("long working address joined wrong");

	// a working access only ever reaches one of the two named slices
	chk_work_slice_only: assert property (
		(i_req && i_mode == regfile_pkg::MODE_WORK4)
		|=> o_offset[7:3] == $past(o_wsp0[7:3]) || o_offset[7:3] == $past(o_wsp1[7:3]))
		else $error("working access left the named slices");
endmodule

// ===== design/regfile_defines.svh
/*
 * Register offsets, option addresses, reset values and field positions
 * for the register file page decoder.
 * Assumes it is included by bare name and never holds logic.
 */
`ifndef REGFILE_DEFINES_SVH
`define REGFILE_DEFINES_SVH

// register offsets inside set 1
`define RF_OFS_WSP0 8'hD6
`define RF_OFS_WSP1 8'hD7
`define RF_OFS_PAGE 8'hDF

// reset values
`define RF_RST_WSP0 8'hC0
`define RF_RST_WSP1 8'hC8
`define RF_RST_PAGE 8'h00

// set boundaries
`define RF_SET_BASE 8'hC0
`define RF_BANK_BASE 8'hE0
`define RF_SYS_BASE 8'hD0
`define RF_WORK_NIB 4'hC

// slice step for the set-both-pointers instruction
`define RF_SLICE_STEP 8'h08

// highest page that carries set 2
`define RF_SET2_MAX_PAGE 4'h7

// program-memory option cells
`define RF_OPT_FIRST 16'h003C
`define RF_OPT_LOW 16'h003E
`define RF_OPT_HIGH 16'h003F

// page select fields
`define RF_PAGE_SRC_LSB 0
`define RF_PAGE_DST_LSB 4

`endif

// ===== design/regfile_pkg.sv
/*
 * Types shared by the register file page decoder and its helpers.
 * Assumes the defines header supplies all numeric constants.
 */
package regfile_pkg;

	// addressing mode of a cpu register access
	typedef enum logic [1:0] {
		MODE_DIRECT = 2'h0,
		MODE_INDIRECT = 2'h1,
		MODE_INDEXED = 2'h2,
		MODE_WORK4 = 2'h3
	} access_mode_e;

	// region the access resolves to, one-hot except AREA_NONE, which is zero
	typedef enum logic [5:0] {
		AREA_NONE = 6'h00,
		AREA_PRIME = 6'h01,
		AREA_COMMON = 6'h02,
		AREA_SYSTEM = 6'h04,
		AREA_BANK0 = 6'h08,
		AREA_BANK1 = 6'h10,
		AREA_SET2 = 6'h20
	} area_e;

	// pointer and bank instructions
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_SET_BOTH = 3'h1,
		CMD_SET_FIRST = 3'h2,
		CMD_SET_SECOND = 3'h3,
		CMD_BANK_ZERO = 3'h4,
		CMD_BANK_ONE = 3'h5
	} ptr_cmd_e;

endpackage

// ===== design/regfile_if.sv
/*
 * Carrier between the decoder and its working address resolver.
 * Assumes one clock domain; the resolver is purely combinational.
 */
`timescale 1ns/100ps

interface regfile_if;
	logic [7:0] addr;
	regfile_pkg::access_mode_e mode;
	logic [7:0] wsp0;
	logic [7:0] wsp1;
	logic [7:0] res_addr;
	logic working;

	modport resolver (
		input addr,
		input mode,
		input wsp0,
		input wsp1,
		output res_addr,
		output working
	);

	modport owner (
		output addr,
		output mode,
		output wsp0,
		output wsp1,
		input res_addr,
		input working
	);
endinterface

// ===== design/working_addr_resolver.sv
/*
 * Combinational working-register address resolver.
 * Assumes the pointers arrive already registered from the owner.
 */
`timescale 1ns/100ps
`include "regfile_defines.svh"

module working_addr_resolver (
	regfile_if.resolver rif // request in, resolved address out
);

	// top five bits of the chosen pointer joined to three low address bits
	function automatic logic [7:0] join_slice(input logic [7:0] p0, input logic [7:0] p1,
		input logic [3:0] nib);
		logic [7:0] ptr;
		ptr = nib[3] ? p1 : p0;
		return {ptr[7:3], nib[2:0]};
	endfunction

	// short form, or long form flagged by the 1100 upper nibble
	always_comb begin
		rif.working = 1'b0;
		rif.res_addr = rif.addr;
		if (rif.mode == regfile_pkg::MODE_WORK4) begin
			rif.working = 1'b1;
			rif.res_addr = join_slice(rif.wsp0, rif.wsp1, rif.addr[3:0]);
		end else if (rif.mode == regfile_pkg::MODE_DIRECT && rif.addr[7:4] == `RF_WORK_NIB) begin
			rif.working = 1'b1;
			rif.res_addr = join_slice(rif.wsp0, rif.wsp1, rif.addr[3:0]);
		end
	end

endmodule

// ===== design/option_store.sv
/*
 * Start-option cells of program memory.
 * Assumes run-time writes and programmer writes never coincide.
 */
`timescale 1ns/100ps
`include "regfile_defines.svh"

module option_store (
	input wire logic i_clk, // system clock
	input wire logic i_arst_n, // async reset, active low
	input wire logic i_pm_we, // run-time program-memory write
	input wire logic i_prog_we, // external programmer write
	input wire logic [15:0] i_pm_addr, // program-memory address
	input wire logic [7:0] i_pm_wdata, // write data
	output logic [7:0] o_opt_rdata, // stored byte at i_pm_addr
	output logic [15:0] o_start_option // active start option
);

	typedef struct packed {
		logic [3:0][7:0] cells;
		logic [15:0] active;
		logic [7:0] rdata;
	} opt_state_s;

	opt_state_s st_q;
	opt_state_s st_d;
	logic in_area;

	assign in_area = (i_pm_addr[15:2] == 14'(`RF_OPT_FIRST >> 2));

	// cells follow every write; the active option follows the programmer only
	always_comb begin
		st_d = st_q;
		st_d.rdata = in_area ? st_q.cells[i_pm_addr[1:0]] : 8'h00;
		if ((i_pm_we || i_prog_we) && in_area) begin
			st_d.cells[i_pm_addr[1:0]] = i_pm_wdata;
		end
		if (i_prog_we && i_pm_addr == `RF_OPT_LOW) begin
			st_d.active[7:0] = i_pm_wdata;
		end
		if (i_prog_we && i_pm_addr == `RF_OPT_HIGH) begin
			st_d.active[15:8] = i_pm_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_opt_rdata = st_q.rdata;
	assign o_start_option = st_q.active;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	chk_option_runtime_blocked: assert property (
		(i_pm_we && !i_prog_we) |=> o_start_option == $past(o_start_option))
		else $error("run-time write changed the start option");
	chk_option_high_load: assert property (
		(i_prog_we && i_pm_addr == `RF_OPT_HIGH) |=> o_start_option[15:8] == $past(i_pm_wdata))
		else $error("programmer write to high option cell lost");
	chk_option_unused_cells: assert property (
		(i_prog_we && i_pm_addr[15:1] == 15'(`RF_OPT_FIRST >> 1)) |=> $stable(o_start_option))
		else $error("unused option cell changed the start option");
endmodule

// ===== test/cpu_core_model.sv
/*
 * Behavioural cpu core: issues register accesses and pointer commands.
 * Assumes a caller invokes its tasks; signals change at falling edges.
 */
`timescale 1ns/100ps

module cpu_core_model (
	input wire logic i_clk, // system clock
	output logic o_req, // access request
	output logic o_we, // write access
	output logic o_pair, // pair access
	output regfile_pkg::access_mode_e o_mode, // addressing mode
	output logic [7:0] o_addr, // register address
	output logic [7:0] o_wdata, // write data
	output regfile_pkg::ptr_cmd_e o_cmd, // pointer or bank command
	output logic [7:0] o_cmd_operand // command operand
);
	// idle bus from time zero
	initial begin
		o_req = 1'b0;
		o_we = 1'b0;
		o_pair = 1'b0;
		o_mode = regfile_pkg::MODE_DIRECT;
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_cmd = regfile_pkg::CMD_NONE;
		o_cmd_operand = 8'h00;
	end

	// one access held for a whole cycle; released lines show a new pattern, not the old value
	// common area reached only through the working forms of address
	task automatic access(input logic we, input logic pair, input regfile_pkg::access_mode_e mode,
		input logic [7:0] addr, input logic [7:0] wdata);
		@(negedge i_clk);
		o_req = 1'b1;
		o_we = we;
		o_pair = pair;
		o_mode = mode;
		o_addr = addr;
		o_wdata = wdata;
		@(negedge i_clk);
		o_req = 1'b0;
		o_addr = ~addr;
		o_wdata = ~wdata;
	endtask

	// one instruction, one cycle
	task automatic command(input regfile_pkg::ptr_cmd_e cmd, input logic [7:0] op);
		@(negedge i_clk);
		o_cmd = cmd;
		o_cmd_operand = op;
		@(negedge i_clk);
		o_cmd = regfile_pkg::CMD_NONE;
		o_cmd_operand = ~op;
	endtask
endmodule

// ===== test/register_file_paging_decoder_bench.sv
/*
 * Self-checking bench for the register file page decoder.
 * Assumes the cpu core model drives the access side; option cells driven here.
 */
`timescale 1ns/100ps

module register_file_paging_decoder_bench;
	logic i_clk, i_arst_n, req, we, pair, pm_we, prog_we;
	regfile_pkg::access_mode_e mode;
	regfile_pkg::ptr_cmd_e cmd;
	logic [7:0] addr, wdata, cmd_op, pm_wdata, ew0, ew1, epg;
	logic [15:0] pm_addr;
	logic eb, o_valid, o_int_hit, o_page_err, o_bank;
	regfile_pkg::area_e o_area;
	logic [3:0] o_page;
	logic [7:0] o_offset, o_pair_low, o_rdata, o_page_sel, o_wsp0, o_wsp1, o_opt_rdata;
	logic [15:0] o_start_option;
	int n_mismatch, comparisons, cycles;

	cpu_core_model u_cpu (.i_clk(i_clk), .o_req(req), .o_we(we), .o_pair(pair), .o_mode(mode),
		.o_addr(addr), .o_wdata(wdata), .o_cmd(cmd), .o_cmd_operand(cmd_op));

	register_file_paging_decoder u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(req),
		.i_we(we), .i_pair(pair), .i_mode(mode), .i_addr(addr), .i_wdata(wdata), .i_cmd(cmd),
		.i_cmd_operand(cmd_op), .i_pm_we(pm_we), .i_prog_we(prog_we), .i_pm_addr(pm_addr),
		.i_pm_wdata(pm_wdata), .o_valid(o_valid), .o_area(o_area), .o_page(o_page),
		.o_offset(o_offset), .o_pair_low(o_pair_low), .o_int_hit(o_int_hit),
		.o_page_err(o_page_err), .o_rdata(o_rdata), .o_bank(o_bank), .o_page_sel(o_page_sel),
		.o_wsp0(o_wsp0), .o_wsp1(o_wsp1), .o_opt_rdata(o_opt_rdata),
		.o_start_option(o_start_option));

	// 8 ns clock
	initial i_clk = 1'b0;
	always #4 i_clk = ~i_clk;

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// hang guard, far above the several hundred cycles the run needs
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			report_and_stop;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// expected {area, page, offset} from the bench's own copy of the registers
	function automatic logic [17:0] exp_dec(input logic w, input logic [1:0] m,
		input logic [7:0] a, input logic p);
		logic [7:0] r;
		logic [7:0] ptr;
		logic [5:0] ar;
		logic [3:0] pg;
		logic wk;
		wk = (m == 2'h3) || (m == 2'h0 && a[7:4] == 4'hC);
		ptr = a[3] ? ew1 : ew0;
		r = wk ? {ptr[7:3], a[2:0]} : a;
		pg = w ? epg[7:4] : epg[3:0];
		if (r < 8'hC0)
			ar = 6'h01;
		else if (wk || m == 2'h0) begin
			pg = 4'h0;
			ar = (r >= 8'hE0) ? (eb ? 6'h10 : 6'h08) : (r >= 8'hD0 ? 6'h04 : 6'h02);
		end else
			ar = 6'h20;
		return {ar, pg, p ? {r[7:1], 1'b0} : r};
	endfunction

	// one access with its decode outputs compared, hit only for single bytes and read data only for single-byte reads; pointer writes tracked
	task automatic acc(input logic w, input logic p, input logic [1:0] m, input logic [7:0] a,
		input logic [7:0] d);
		logic [17:0] e;
		logic h;
		e = exp_dec(w, m, a, p);
		h = e[17:12] == 6'h04 && (e[7:0] == 8'hD6 || e[7:0] == 8'hD7 || e[7:0] == 8'hDF);
		u_cpu.access(w, p, regfile_pkg::access_mode_e'(m), a, d);
		check(o_valid, 1'b1);
		check(o_area, e[17:12]);
		check(o_page, e[11:8]);
		check(o_offset, e[7:0]);
		check(o_pair_low, e[7:0] | 8'h01);
		check(o_page_err, e[17:12] == 6'h20 && e[11]);
		if (!p)
			check(o_int_hit, h);
		if (!p && !w)
			check(o_rdata, !h ? 8'h00 : e[7:0] == 8'hD6 ? ew0 : e[7:0] == 8'hD7 ? ew1 : epg);
		if (h && w) begin
			if (e[7:0] == 8'hD6)
				ew0 = d;
			else if (e[7:0] == 8'hD7)
				ew1 = d;
			else
				epg = d;
		end
	endtask

	task automatic cmd_do(input logic [2:0] c, input logic [7:0] op);
		u_cpu.command(regfile_pkg::ptr_cmd_e'(c), op);
		case (c)
			3'h1: begin
				ew0 = op;
				ew1 = op + 8'h08;
			end
			3'h2: ew0 = op;
			3'h3: ew1 = op;
			3'h4: eb = 1'b0;
			3'h5: eb = 1'b1;
			default: ;
		endcase
		check({o_wsp0, o_wsp1}, {ew0, ew1});
		check({o_page_sel, 7'h00, o_bank}, {epg, 7'h00, eb});
	endtask

	task automatic pm_write(input logic prog, input logic [15:0] a, input logic [7:0] d);
		@(negedge i_clk);
		prog_we = prog;
		pm_we = !prog;
		pm_addr = a;
		pm_wdata = d;
		@(negedge i_clk);
		prog_we = 1'b0;
		pm_we = 1'b0;
		pm_wdata = ~d;
	endtask

	initial begin
		logic [31:0] r;
		logic [17:0] e;
		logic w, p;
		i_arst_n = 1'b0;
		{pm_we, prog_we, pm_addr, pm_wdata} = '0;
		{n_mismatch, comparisons, cycles} = '0;
		ew0 = 8'hC0;
		ew1 = 8'hC8;
		epg = 8'h00;
		eb = 1'b0;
		void'($urandom(32'h8c4dd708));
		repeat (8) @(negedge i_clk);
		i_arst_n = 1'b1;
		check({o_wsp0, o_wsp1}, 16'hC0C8);
		check({o_page_sel, 7'h00, o_bank}, 16'h0000);
		check(o_start_option, 16'h0000);
		// reset pointers give the common area through both working forms
		acc(1'b0, 1'b0, 2'h3, 8'h02, 8'h00);
		acc(1'b0, 1'b0, 2'h0, 8'hCA, 8'h00);
		// every instruction, including an operand whose plus eight wraps
		cmd_do(3'h1, 8'h70);
		cmd_do(3'h3, 8'h48);
		cmd_do(3'h2, 8'hA0);
		cmd_do(3'h1, 8'hF8);
		cmd_do(3'h5, 8'h00);
		acc(1'b0, 1'b0, 2'h0, 8'hE5, 8'h00);
		acc(1'b0, 1'b0, 2'h3, 8'h08, 8'h00);
		cmd_do(3'h4, 8'h00);
		// plain loads of pointers and page select, second pointer and page select read back, then used
		acc(1'b1, 1'b0, 2'h0, 8'hD6, 8'h30);
		acc(1'b1, 1'b0, 2'h0, 8'hD7, 8'hF0);
		acc(1'b1, 1'b0, 2'h0, 8'hDF, 8'h92);
		acc(1'b0, 1'b0, 2'h0, 8'hD7, 8'h00);
		acc(1'b0, 1'b0, 2'h0, 8'hDF, 8'h00);
		acc(1'b1, 1'b0, 2'h1, 8'hC4, 8'h00);
		acc(1'b0, 1'b0, 2'h2, 8'hC4, 8'h00);
		acc(1'b0, 1'b1, 2'h3, 8'h0B, 8'h00);
		// random mix; the page select is the only system register written here, others only read, so tracking stays exact
		repeat (300) begin
			r = $urandom;
			if (r[3:0] == 4'h0)
				cmd_do(3'($urandom_range(5, 1)), r[31:24]);
			else if (r[3:0] == 4'h1)
				acc(1'b1, 1'b0, 2'h0, 8'hDF, r[31:24]);
			else begin
				w = r[4];
				p = r[5];
				e = exp_dec(w, r[7:6], r[15:8], p);
				if (e[17:12] == 6'h04) begin
					w = 1'b0;
					p = 1'b0;
				end
				acc(w, p, r[7:6], r[15:8], r[23:16]);
			end
		end
		// option cells: programmer sets the option, run-time writes only the bytes
		pm_write(1'b1, 16'h003E, 8'h5A);
		pm_write(1'b1, 16'h003F, 8'hA5);
		check(o_start_option, 16'hA55A);
		pm_write(1'b1, 16'h003C, 8'h77);
		@(negedge i_clk);
		check(o_opt_rdata, 8'h77);
		check(o_start_option, 16'hA55A);
		pm_write(1'b0, 16'h003F, 8'h11);
		@(negedge i_clk);
		check(o_opt_rdata, 8'h11);
		check(o_start_option, 16'hA55A);
		report_and_stop;
	end
endmodule
